// >>> rtl/qpd_top.sv
// Top of the quadrature pulse divider with its register port.
// Assumes encoder pins asynchronous to sys_clk and a software master on sys_clk.
`timescale 1ns/1ns
module qpd_top (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Register port.
   input wire logic [qpd_pkg::REG_AW-1:0] reg_addr,
   input wire logic [qpd_pkg::REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [qpd_pkg::REG_DW-1:0] reg_rdata,
   // Encoder inputs.
   input wire logic encoder_phase_a_in,
   input wire logic encoder_phase_b_in,
   input wire logic encoder_zero_mark_in,
   // Divided outputs.
   output logic div_phase_a_out,
   output logic div_phase_b_out,
   output logic zero_mark_out
);
   import qpd_pkg::*;

   logic [REG_DW-1:0] software_control_bits;
   logic [DIV_SEL_W-1:0] div_sel;
   logic [REG_DW-1:0] zero_mark_pulse_width;
   logic rev_sticky;
   logic enable;
   logic [PIN_N-1:0] pin_lvl;
   logic [PIN_N-1:0] pin_rise;
   logic [PIN_N-1:0] pin_fall;
   logic [CNT_W-1:0] divider;
   logic [CNT_W-1:0] match1;
   logic [CNT_W-1:0] match2;
   logic [CNT_W-1:0] step_cnt;
   logic [CNT_W-1:0] next_step_cnt;
   logic count_en;
   logic hit1;
   logic hit2;
   qpd_half_t half;
   logic lead_is_a;
   qpd_zm_t zm_state;
   logic [REG_DW-1:0] zm_cnt;
   logic [REG_DW-1:0] zm_last;
   logic zm_start;

   qpd_step_if step_bus ();

   qpd_sync_edge #(
      .WIDTH(PIN_N)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin({encoder_zero_mark_in, encoder_phase_b_in, encoder_phase_a_in}),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   qpd_dir_fsm u_dir (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(enable),
      .a_lvl(pin_lvl[PIN_A]),
      .b_lvl(pin_lvl[PIN_B]),
      .a_edge(pin_rise[PIN_A] | pin_fall[PIN_A]),
      .b_edge(pin_rise[PIN_B] | pin_fall[PIN_B]),
      .step_bus(step_bus.src)
   );

   assign enable = software_control_bits[CTRL_EN_BIT];

   // Register writes.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         software_control_bits <= '0;
      else if (reg_wr && reg_addr == ADDR_CTRL)
         software_control_bits <= reg_wdata;
   end

   // Settings above 11 are clamped so the counter width always suffices.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         div_sel <= DIV_SEL_RST;
      else if (reg_wr && reg_addr == ADDR_DIV)
         div_sel <= (reg_wdata[DIV_SEL_W-1:0] > DIV_SEL_MAX) ? DIV_SEL_MAX
            : reg_wdata[DIV_SEL_W-1:0];
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         zero_mark_pulse_width <= ZMW_RST;
      else if (reg_wr && reg_addr == ADDR_ZMW)
         zero_mark_pulse_width <= reg_wdata;
   end

   // Reversal flag: a new reversal wins over a write-one clear.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rev_sticky <= 1'b0;
      else if (step_bus.reversal)
         rev_sticky <= 1'b1;
      else if (reg_wr && reg_addr == ADDR_STAT && reg_wdata[STAT_REV_BIT])
         rev_sticky <= 1'b0;
   end

   // Read data stand in the cycle after the strobe only.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= '0;
      else if (!reg_rd)
         reg_rdata <= '0;
      else
      begin
         unique case (reg_addr)
            ADDR_CTRL: reg_rdata <= software_control_bits;
            ADDR_DIV: reg_rdata <= REG_DW'(div_sel);
            ADDR_ZMW: reg_rdata <= zero_mark_pulse_width;
            ADDR_STAT:
            begin
               reg_rdata <= '0;
               reg_rdata[STAT_FWD_BIT] <= step_bus.fwd;
               reg_rdata[STAT_PA_BIT] <= div_phase_a_out;
               reg_rdata[STAT_PB_BIT] <= div_phase_b_out;
               reg_rdata[STAT_ZM_BIT] <= zero_mark_out;
               reg_rdata[STAT_REV_BIT] <= rev_sticky;
            end
            default: reg_rdata <= '0;
         endcase
      end
   end

   // Match thresholds follow the divider at once.
   assign divider = CNT_W'(1) << div_sel;
   assign match1 = divider << MATCH1_SHIFT;
   assign match2 = divider << MATCH2_SHIFT;

   assign count_en = enable & step_bus.quadrature_step_clock;
   assign next_step_cnt = step_cnt + CNT_W'(1);
   assign hit1 = count_en && next_step_cnt == match1;
   assign hit2 = count_en && next_step_cnt >= match2;

   // A divider change mid-run is caught by the >= compare, so the counter never runs away.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         step_cnt <= '0;
      else if (!enable)
         step_cnt <= '0;
      else if (hit2)
         step_cnt <= '0;
      else if (count_en)
         step_cnt <= next_step_cnt;
   end

   // Half FSM: first match toggles the leading phase, second the lagging one.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         half <= QPD_HALF_LEAD;
      else if (!enable)
         half <= QPD_HALF_LEAD;
      else
      begin
         unique case (half)
            QPD_HALF_LEAD: if (hit1) half <= QPD_HALF_LAG;
            QPD_HALF_LAG: if (hit2) half <= QPD_HALF_LEAD;
         endcase
      end
   end

   assign lead_is_a = step_bus.fwd;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         div_phase_a_out <= 1'b0;
      else if (!enable)
         div_phase_a_out <= 1'b0;
      else if ((half == QPD_HALF_LEAD && hit1 && lead_is_a)
         || (half == QPD_HALF_LAG && hit2 && !lead_is_a))
         div_phase_a_out <= ~div_phase_a_out;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         div_phase_b_out <= 1'b0;
      else if (!enable)
         div_phase_b_out <= 1'b0;
      else if ((half == QPD_HALF_LEAD && hit1 && !lead_is_a)
         || (half == QPD_HALF_LAG && hit2 && lead_is_a))
         div_phase_b_out <= ~div_phase_b_out;
   end

   // Zero mark pulse; a width of zero behaves as one cycle.
   assign zm_start = enable & pin_rise[PIN_ZM];
   assign zm_last = (zero_mark_pulse_width == '0) ? '0
      : zero_mark_pulse_width - REG_DW'(1);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         zm_state <= QPD_ZM_IDLE;
      else if (!enable)
         zm_state <= QPD_ZM_IDLE;
      else
      begin
         unique case (zm_state)
            QPD_ZM_IDLE: if (zm_start) zm_state <= QPD_ZM_PULSE;
            QPD_ZM_PULSE: if (zm_cnt == zm_last) zm_state <= QPD_ZM_IDLE;
         endcase
      end
   end

   // Edges arriving during a pulse are ignored rather than stretching it.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         zm_cnt <= '0;
      else if (!enable || zm_state == QPD_ZM_IDLE)
         zm_cnt <= '0;
      else
         zm_cnt <= zm_cnt + REG_DW'(1);
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         zero_mark_out <= 1'b0;
      else if (!enable)
         zero_mark_out <= 1'b0;
      else if (zm_state == QPD_ZM_IDLE)
         zero_mark_out <= zm_start;
      else
         zero_mark_out <= zm_cnt != zm_last;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_hit1;
      hit1 && half == QPD_HALF_LEAD;
   endsequence
   sequence s_hit2;
      hit2 && half == QPD_HALF_LAG;
   endsequence

   AST_DIV_RANGE: assert property (div_sel <= DIV_SEL_MAX)
      else $error("Divider select out of range.");
   AST_MATCH_RATIO: assert property (match2 == (match1 << 1) && match1 == (divider << 1))
      else $error("Match thresholds not four and two times the divider.");
   AST_RESTART: assert property (s_hit2 |=> step_cnt == '0)
      else $error("Counter did not restart at second match.");
   AST_NO_COUNT_OFF: assert property (!enable |=> step_cnt == '0 && !div_phase_a_out
      && !div_phase_b_out && !zero_mark_out)
      else $error("Disabled block still counting or driving.");
   AST_LEAD_TOGGLE: assert property ((s_hit1 and lead_is_a)
      |=> div_phase_a_out != $past(div_phase_a_out)
      && div_phase_b_out == $past(div_phase_b_out))
      else $error("Forward lead toggle went to the wrong phase.");
   AST_REV_ORDER: assert property ((s_hit1 and (!lead_is_a && enable))
      |=> div_phase_b_out != $past(div_phase_b_out))
      else $error("Reverse motion did not lead with phase B.");
   // Software may only see a reversal through the sticky flag, so it must never be lost.
   AST_REV_STICKY: assert property (step_bus.reversal |=> rev_sticky)
      else $error("Reversal was not recorded in the status flag.");
   AST_ZM_START: assert property (zm_start && zm_state == QPD_ZM_IDLE |=> zero_mark_out)
      else $error("Zero mark edge produced no pulse.");
   AST_ZM_WIDTH: assert property (enable && zero_mark_pulse_width == REG_DW'(2)
      && zm_start && zm_state == QPD_ZM_IDLE
      ##1 enable [*2] |-> zero_mark_out ##1 !zero_mark_out)
      else $error("Zero mark pulse width mismatch.");
   AST_HALF_PERIOD: assert property (s_hit1 |-> step_cnt == match1 - CNT_W'(1))
      else $error("First match not at twice the divider.");
endmodule

// >>> rtl/qpd_pkg.sv
// Constants, field positions and state types of the quadrature pulse divider.
// Assumes a single 20 MHz system clock shared by every module of the block.
package qpd_pkg;
   // Register port.
   localparam int REG_AW = 3;
   localparam int REG_DW = 16;
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_DIV = 3'h1;
   localparam logic [2:0] ADDR_ZMW = 3'h2;
   localparam logic [2:0] ADDR_STAT = 3'h3;
   localparam int CTRL_EN_BIT = 0;
   localparam int STAT_FWD_BIT = 0;
   localparam int STAT_PA_BIT = 1;
   localparam int STAT_PB_BIT = 2;
   localparam int STAT_ZM_BIT = 3;
   localparam int STAT_REV_BIT = 4;
   // Divider select is the power of two of the divider, 0 to 11.
   localparam int DIV_SEL_W = 4;
   localparam logic [3:0] DIV_SEL_MAX = 4'hb;
   localparam logic [3:0] DIV_SEL_RST = 4'h0;
   localparam int CNT_W = 14;
   localparam int MATCH1_SHIFT = 1;
   localparam int MATCH2_SHIFT = 2;
   localparam logic [15:0] ZMW_RST = 16'h0001;
   // Encoder input limit and the least input period it implies.
   localparam int SYS_CLK_KHZ = 20000;
   localparam int ENC_MAX_KHZ = 5000;
   localparam int ENC_MIN_PERIOD_CYC = (SYS_CLK_KHZ + ENC_MAX_KHZ - 1) / ENC_MAX_KHZ;
   // Synchroniser pin order.
   localparam int PIN_A = 0;
   localparam int PIN_B = 1;
   localparam int PIN_ZM = 2;
   localparam int PIN_N = 3;
   typedef enum logic [1:0] {QPD_EXP_A = 2'b01, QPD_EXP_B = 2'b10} qpd_phase_sel_t;
   typedef enum logic [1:0] {QPD_HALF_LEAD = 2'b01, QPD_HALF_LAG = 2'b10} qpd_half_t;
   typedef enum logic [1:0] {QPD_ZM_IDLE = 2'b01, QPD_ZM_PULSE = 2'b10} qpd_zm_t;
endpackage

// >>> rtl/qpd_step_if.sv
// Step clock bundle from the direction stage to the output stage.
// Assumes both ends run on sys_clk; step and reversal are one-cycle pulses.
`timescale 1ns/1ns
interface qpd_step_if;
   logic quadrature_step_clock;
   logic fwd;
   logic reversal;
   modport src (output quadrature_step_clock, output fwd, output reversal);
   modport snk (input quadrature_step_clock, input fwd, input reversal);
endinterface

// >>> rtl/qpd_sync_edge.sv
// Two-stage synchronisers and edge detectors for the encoder pins.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/1ns
module qpd_sync_edge #(
   parameter int WIDTH = 3
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Raw pins.
   input wire logic [WIDTH-1:0] pin,
   // Synchronised levels and edge pulses.
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] prev;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_pin
         // The first stage feeds only the second stage.
         always_ff @(posedge sys_clk or posedge rst)
         begin
            if (rst)
            begin
               meta[i] <= 1'b0;
               level[i] <= 1'b0;
               prev[i] <= 1'b0;
            end
            else
            begin
               meta[i] <= pin[i];
               level[i] <= meta[i];
               prev[i] <= level[i];
            end
         end
         assign rise[i] = level[i] & ~prev[i];
         assign fall[i] = ~level[i] & prev[i];
      end
   endgenerate
endmodule

// >>> rtl/qpd_dir_fsm.sv
// Direction stage: alternates between the phases and makes the step clock.
// Assumes synchronised levels and edge pulses on sys_clk.
`timescale 1ns/1ns
module qpd_dir_fsm (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Control.
   input wire logic enable,
   // Phase levels and edges.
   input wire logic a_lvl,
   input wire logic b_lvl,
   input wire logic a_edge,
   input wire logic b_edge,
   // Step clock towards the output stage.
   qpd_step_if.src step_bus
);
   import qpd_pkg::*;
   qpd_phase_sel_t expect_phase;
   logic edge_ok;
   logic next_fwd;
   // Both phases moving at once is not a legal quadrature step and is dropped.
   assign edge_ok = enable & (a_edge ^ b_edge);
   assign next_fwd = a_edge ? (a_lvl ^ b_lvl) : ~(a_lvl ^ b_lvl);
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         expect_phase <= QPD_EXP_A;
      else if (!enable)
         expect_phase <= QPD_EXP_A;
      else if (edge_ok)
         expect_phase <= a_edge ? QPD_EXP_B : QPD_EXP_A;
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         step_bus.fwd <= 1'b1;
      else if (edge_ok)
         step_bus.fwd <= next_fwd;
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         step_bus.quadrature_step_clock <= 1'b0;
         step_bus.reversal <= 1'b0;
      end
      else
      begin
         step_bus.quadrature_step_clock <= edge_ok;
         step_bus.reversal <= edge_ok & (next_fwd != step_bus.fwd);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_DIR_FROM_PHASES: assert property (edge_ok |=> step_bus.fwd == $past(next_fwd))
      else $error("Direction does not follow the phase relation.");
   AST_REVERSAL_SEEN: assert property (edge_ok && next_fwd != step_bus.fwd
      |=> step_bus.reversal && step_bus.quadrature_step_clock)
      else $error("Direction change not flagged as reversal.");
   AST_EXPECT_ALT: assert property (edge_ok && a_edge |=> expect_phase == QPD_EXP_B)
      else $error("Phase tracker did not move to phase B.");
endmodule

// >>> tb/qpd_enc_model.sv
// Behavioural incremental encoder that drives the divider's three pins.
// Assumes the bench calls its tasks from one process clocked by sys_clk.
`timescale 1ns/1ns
module qpd_enc_model (
   // Clock.
   input wire logic sys_clk,
   // Encoder pins.
   output logic phase_a,
   output logic phase_b,
   output logic zero_mark
);
   int pos = 0;

   initial
   begin
      phase_a = 1'b0;
      phase_b = 1'b0;
      zero_mark = 1'b0;
   end

   // One quadrature edge per call round; four clocks apart holds the rate at the limit, ENC_MIN_PERIOD_CYC.
   task automatic step(input bit fwd, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge sys_clk);
         pos = fwd ? (pos + 1) % 4 : (pos + 3) % 4;
         phase_a <= (pos == 1) || (pos == 2);
         phase_b <= (pos >= 2);
         repeat (3) @(posedge sys_clk);
      end
   endtask

   // A short zero mark; two clocks high is the shortest that the synchroniser is sure to see.
   task automatic mark();
      @(posedge sys_clk);
      zero_mark <= 1'b1;
      repeat (2) @(posedge sys_clk);
      zero_mark <= 1'b0;
   endtask
endmodule

// >>> tb/qpd_top_bench.sv
// Self-checking bench for the quadrature pulse divider top.
// Assumes the encoder model in qpd_enc_model and the register map of qpd_pkg.
`timescale 1ns/1ns
module qpd_top_bench;
   import qpd_pkg::*;
   localparam logic [1:0] FWD_SEQ [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
   localparam logic [1:0] REV_SEQ [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
   localparam int ZW [4] = '{0, 1, 2, 5};
   localparam int ZE [4] = '{1, 1, 2, 5};
   logic sys_clk;
   logic rst;
   logic [REG_AW-1:0] reg_addr;
   logic [REG_DW-1:0] reg_wdata;
   logic [REG_DW-1:0] reg_rdata;
   logic [REG_DW-1:0] rdata;
   logic reg_wr;
   logic reg_rd;
   logic pa;
   logic pb;
   logic zm;
   logic qa;
   logic qb;
   logic qz;
   int n_errors = 0;
   int num_checks = 0;

   qpd_enc_model enc (.sys_clk(sys_clk), .phase_a(pa), .phase_b(pb), .zero_mark(zm));

   qpd_top dut (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .encoder_phase_a_in(pa), .encoder_phase_b_in(pb), .encoder_zero_mark_in(zm),
      .div_phase_a_out(qa), .div_phase_b_out(qb), .zero_mark_out(qz)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rchk(input logic [2:0] a, input logic [15:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rdata = reg_rdata;
      chk(what, rdata, exp);
   endtask

   // Output toggles land four clocks after the pin change; the step ends three after it.
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task automatic zm_pulse(input int exp, input string what);
      int hi;
      hi = 0;
      enc.mark();
      for (int w = 0; w < 20; w++)
      begin
         @(posedge sys_clk);
         #1;
         if (qz === 1'b1)
            hi++;
      end
      chk(what, 16'(hi), 16'(exp));
   endtask

   task automatic wrap_up();
      $display("checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(ADDR_CTRL, 16'h0000, "ctrl reset");
      rchk(ADDR_DIV, 16'h0000, "div reset");
      rchk(ADDR_ZMW, ZMW_RST, "width reset");
      rchk(ADDR_STAT, 16'h0001, "status reset");
      wr(3'h5, 16'hffff);
      rchk(3'h5, 16'h0000, "unmapped");
      wr(ADDR_DIV, 16'h000f);
      rchk(ADDR_DIV, {12'h000, DIV_SEL_MAX}, "div clamp");
      // Nothing may move while the enable bit is clear.
      enc.step(1'b1, 8);
      settle();
      chk("disabled phases", {14'h0, qa, qb}, 16'h0000);
      zm_pulse(0, "disabled mark");
      for (int k = 0; k < 4; k++)
      begin
         wr(ADDR_CTRL, 16'h0000);
         wr(ADDR_DIV, k[15:0]);
         wr(ADDR_CTRL, 16'h0001);
         for (int q = 0; q < 4; q++)
         begin
            enc.step(1'b1, 2 << k);
            settle();
            chk("fwd phases", {14'h0, qa, qb}, {14'h0, FWD_SEQ[q]});
         end
      end
      rchk(ADDR_STAT, 16'h0001, "fwd status");
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_DIV, 16'h0000);
      wr(ADDR_CTRL, 16'h0001);
      for (int q = 0; q < 4; q++)
      begin
         enc.step(1'b0, 2);
         settle();
         chk("rev phases", {14'h0, qa, qb}, {14'h0, REV_SEQ[q]});
      end
      rchk(ADDR_STAT, 16'h0010, "rev status");
      wr(ADDR_STAT, 16'h0010);
      rchk(ADDR_STAT, 16'h0000, "rev cleared");
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_ZMW, 16'(ZW[i]));
         zm_pulse(ZE[i], "mark width");
      end
      // The largest divider: the leading phase must wait exactly 4096 steps.
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_DIV, 16'h000b);
      wr(ADDR_CTRL, 16'h0001);
      enc.step(1'b1, 4095);
      settle();
      chk("div max early", {14'h0, qa, qb}, 16'h0000);
      enc.step(1'b1, 1);
      settle();
      chk("div max match", {14'h0, qa, qb}, 16'h0002);
      wr(ADDR_CTRL, 16'h0000);
      @(posedge sys_clk);
      #1;
      chk("disable clears", {14'h0, qa, qb}, 16'h0000);
      wrap_up();
   end

   // The full run needs about 17200 clocks; this limit leaves ample margin.
   initial
   begin
      repeat (40000) @(posedge sys_clk);
      n_errors++;
      wrap_up();
   end
endmodule
